/* pss_pkg.sv */
// Constants, register map and state codes of the power state and supply controller
package pss_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int STEP_TIME_US = 10;
  localparam int STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_GEN_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAKE_LO = 8'h04;
  localparam logic [7:0] OFS_WAKE_HI = 8'h08;
  localparam logic [7:0] OFS_AWAKE_CFG = 8'h18;
  localparam logic [7:0] OFS_SLP1_CFG = 8'h1C;
  localparam logic [7:0] OFS_SEQ_STAT = 8'h24;
  localparam logic [7:0] OFS_CONV_CTRL = 8'h2C;
  localparam logic [7:0] OFS_SUP_STAT = 8'h30;
  localparam logic [7:0] OFS_CORE_LVL = 8'h34;
  localparam logic [7:0] OFS_PLL_LVL = 8'h40;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h50;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h54;
  // ==========================================================
  // Field positions
  localparam int B_G_REAPPLY = 6;
  localparam int B_G_USE64 = 5;
  localparam int B_G_TIMER = 4;
  localparam int B_G_SLEEP = 1;
  localparam int B_TILE_STOP = 14;
  localparam int B_ANA_PFM = 9;
  localparam int B_CORE_PFM = 8;
  localparam int B_IO_EN = 5;
  localparam int B_PLL_EN = 4;
  localparam int B_ANA_EN = 1;
  localparam int B_CORE_EN = 0;
  localparam int B_STATE_LSB = 16;
  localparam int B_PREV_CORE = 24;
  localparam int B_PREV_PLL = 28;
  localparam int B_OSC_OK = 24;
  localparam int B_PLL_GOOD = 19;
  localparam int B_CORE_GOOD = 16;
  localparam int B_LIMIT_LSB = 8;
  localparam int B_SOFT_LSB = 0;
  localparam int IRQ_AWAKE = 0;
  localparam int IRQ_ASLEEP = 1;
  localparam int IRQ_WAKE = 2;
  // ==========================================================
  // Reset values and masks
  localparam logic [31:0] GEN_RST = 32'h0000_0008;
  localparam logic [31:0] GEN_RW_MASK = 32'h0000_00BD;
  localparam logic [31:0] AWAKE_RST = 32'h0000_0033;
  localparam logic [31:0] AWAKE_WR_MASK = 32'h0000_4331;
  localparam logic [31:0] AWAKE_FIXED = 32'h0000_0002;
  localparam logic [31:0] CFG_MASK = 32'h0000_4333;
  localparam logic [31:0] SLP1_RST = 32'h0000_0002;
  localparam logic [31:0] ASLEEP_CFG = 32'h0000_4002;
  localparam logic [3:0] PREV_RST = 4'h2;
  localparam logic [6:0] CORE_LVL_BASE = 7'h28;
  localparam logic [6:0] CORE_LVL_MAX = 7'h46;
  localparam logic [31:0] PLL_LVL_RST = 32'h0000_0000;
  localparam logic [2:0] IRQ_W = 3'h0;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_ASLEEP = 3'h1,
    ST_POWER_UP_STEP_ONE = 3'h2,
    ST_POWER_UP_STEP_TWO = 3'h3,
    ST_AWAKE_WAIT = 3'h4,
    ST_AWAKE = 3'h5,
    ST_POWER_DOWN_STEP_ONE = 3'h6,
    ST_POWER_DOWN_STEP_TWO = 3'h7
  } pss_state_e;
endpackage

/* pss_power_ctrl.sv */
// Power state sequencer and supply control with an Avalon-MM register slave
// Operation
// - Upper wake word used only with timer wake, 64-bit mode and asleep.
// - Awake config bit 14 stops the tile clock; resets to zero.
// - Bits 9 and 8 pick analogue and core converter modulation, 1 is PULSE_FREQUENCY_MODULATION.
// - Awake enables for IO, PLL and core reset to one; analogue read-only.
// - Sequence status shows supplies enabled in the previous state.
// - Sequence status bits 18:16 show the current state code.
// - Supply status flags oscillator stable, PLL rail and core rail good.
// - Supply status flags each converter in current limiting.
// - Supply status flags each converter in soft-start.
// - Core rail level code 0..70 in 10 mV steps from 0.60V.
// - Core rail level reset value comes from the boot mode pins.
// - General control bit 5 selects 64-bit wake compare, else lower word.
`timescale 1ns/1ps
module pss_power_ctrl #(
  parameter int STEP_CYCLES = pss_pkg::STEP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [63:0] rtc_time,
  input wire logic [3:0] mode_pins,
  input wire logic osc_stable_in,
  input wire logic pll_rail_good_in,
  input wire logic core_rail_good_in,
  input wire logic analogue_limit_in,
  input wire logic core_limit_in,
  input wire logic analogue_softstart_in,
  input wire logic core_softstart_in,
  output logic io_supply_output_en,
  output logic pll_linear_regulator_en,
  output logic analogue_buck_converter_en,
  output logic core_buck_converter_en,
  output logic analogue_buck_pfm,
  output logic core_buck_pfm,
  output logic tile_clock_stop,
  output logic [6:0] core_rail_level,
  output logic [31:0] pll_regulator_level,
  output logic [31:0] converter_control,
  output logic irq
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [6:0] level_clamp(input logic [6:0] v);
    return (v > pss_pkg::CORE_LVL_MAX) ? pss_pkg::CORE_LVL_MAX : v;
  endfunction

  function automatic logic [31:0] cfg_for(
    input pss_pkg::pss_state_e st,
    input logic [31:0] awake_cfg,
    input logic [31:0] slp1_cfg
  );
    logic [31:0] r;
    r = pss_pkg::ASLEEP_CFG;
    if (st == pss_pkg::ST_POWER_DOWN_STEP_ONE)
      r = slp1_cfg;
    else if (st inside {pss_pkg::ST_POWER_UP_STEP_ONE, pss_pkg::ST_POWER_UP_STEP_TWO,
                        pss_pkg::ST_AWAKE_WAIT, pss_pkg::ST_AWAKE})
      r = awake_cfg;
    return r & pss_pkg::CFG_MASK;
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic [3:0] mode_sync;
  logic [6:0] sup_sync;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 11'h000;
      sync2_reg <= 11'h000;
    end
    else if (ce)
    begin
      sync1_reg <= {mode_pins, osc_stable_in, pll_rail_good_in, core_rail_good_in,
                    analogue_limit_in, core_limit_in, analogue_softstart_in,
                    core_softstart_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign mode_sync = sync2_reg[10:7];
  assign sup_sync = sync2_reg[6:0];

  // Strap capture waits until the synchroniser holds settled pins
  logic [1:0] boot_cnt_reg;
  logic boot_done;
  logic boot_cap;

  assign boot_done = (boot_cnt_reg == 2'h3);
  assign boot_cap = (boot_cnt_reg == 2'h2);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      boot_cnt_reg <= 2'h0;
    else if (ce && !boot_done)
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
  end

  // ==========================================================
  // Bus handshake: one wait cycle on every access
  logic wait_reg;
  logic wr_acc;
  logic rd_start;
  logic [31:0] rd_mux;

  assign wr_acc = avs_write && !wait_reg;
  assign rd_start = avs_read && wait_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wait_reg <= 1'b1;
    else if (ce)
    begin
      if (!wait_reg)
        wait_reg <= 1'b1;
      else if (avs_read || avs_write)
        wait_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Software registers
  logic [31:0] gen_reg;
  logic [31:0] wake_lo_reg;
  logic [31:0] wake_hi_reg;
  logic [31:0] awake_cfg_reg;
  logic [31:0] slp1_cfg_reg;
  logic [31:0] conv_reg;
  logic [31:0] pll_lvl_reg;
  logic [6:0] core_lvl_reg;
  logic [2:0] irq_mask_reg;
  logic sleep_req_reg;
  logic reapply_reg;
  pss_pkg::pss_state_e state_reg;
  pss_pkg::pss_state_e state_next;
  logic [31:0] wdata;

  assign wdata = avs_writedata;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      gen_reg <= pss_pkg::GEN_RST;
      wake_lo_reg <= 32'h0000_0000;
      wake_hi_reg <= 32'h0000_0000;
      awake_cfg_reg <= pss_pkg::AWAKE_RST;
      slp1_cfg_reg <= pss_pkg::SLP1_RST;
      conv_reg <= 32'h0000_0000;
      pll_lvl_reg <= pss_pkg::PLL_LVL_RST;
      irq_mask_reg <= pss_pkg::IRQ_W;
    end
    else if (ce && wr_acc)
    begin
      unique case (avs_address)
        pss_pkg::OFS_GEN_CTRL:
          gen_reg <= be_merge(gen_reg, wdata, avs_byteenable) & pss_pkg::GEN_RW_MASK;
        pss_pkg::OFS_WAKE_LO: wake_lo_reg <= be_merge(wake_lo_reg, wdata, avs_byteenable);
        pss_pkg::OFS_WAKE_HI: wake_hi_reg <= be_merge(wake_hi_reg, wdata, avs_byteenable);
        pss_pkg::OFS_AWAKE_CFG:
          awake_cfg_reg <= (be_merge(awake_cfg_reg, wdata, avs_byteenable)
                            & pss_pkg::AWAKE_WR_MASK) | pss_pkg::AWAKE_FIXED;
        pss_pkg::OFS_SLP1_CFG:
          slp1_cfg_reg <= be_merge(slp1_cfg_reg, wdata, avs_byteenable) & pss_pkg::CFG_MASK;
        pss_pkg::OFS_CONV_CTRL: conv_reg <= be_merge(conv_reg, wdata, avs_byteenable);
        pss_pkg::OFS_PLL_LVL: pll_lvl_reg <= be_merge(pll_lvl_reg, wdata, avs_byteenable);
        pss_pkg::OFS_IRQ_MASK:
          if (avs_byteenable[0])
            irq_mask_reg <= wdata[2:0];
        default: ;
      endcase
    end
  end

  // Reset value follows the straps, bus writes clamp to the top code
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      core_lvl_reg <= pss_pkg::CORE_LVL_BASE;
    else if (ce)
    begin
      if (boot_cap)
        core_lvl_reg <= 7'(pss_pkg::CORE_LVL_BASE + {3'h0, mode_sync});
      else if (wr_acc && avs_address == pss_pkg::OFS_CORE_LVL && avs_byteenable[0])
        core_lvl_reg <= level_clamp(wdata[6:0]);
    end
  end

  // Self-clearing commands
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sleep_req_reg <= 1'b0;
      reapply_reg <= 1'b0;
    end
    else if (ce)
    begin
      reapply_reg <= wr_acc && avs_address == pss_pkg::OFS_GEN_CTRL && avs_byteenable[0]
                     && wdata[pss_pkg::B_G_REAPPLY] && state_reg == pss_pkg::ST_AWAKE;
      if (state_reg != pss_pkg::ST_AWAKE)
        sleep_req_reg <= 1'b0;
      else if (wr_acc && avs_address == pss_pkg::OFS_GEN_CTRL && avs_byteenable[0]
               && wdata[pss_pkg::B_G_SLEEP])
        sleep_req_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Wake timer compare
  logic wake_hit;
  logic use64;
  logic timer_en;

  assign use64 = gen_reg[pss_pkg::B_G_USE64];
  assign timer_en = gen_reg[pss_pkg::B_G_TIMER];
  // Upper word is ignored unless the 64-bit compare is selected
  assign wake_hit = timer_en && state_reg == pss_pkg::ST_ASLEEP
                    && (use64 ? (rtc_time >= {wake_hi_reg, wake_lo_reg})
                              : (rtc_time[31:0] >= wake_lo_reg));

  // ==========================================================
  // Sequencer
  logic [15:0] step_cnt_reg;
  logic step_end;
  logic rails_good;

  assign step_end = (step_cnt_reg == 16'(STEP_CYCLES - 1));
  assign rails_good = sup_sync[5] && sup_sync[4];

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      pss_pkg::ST_RESET: if (boot_done) state_next = pss_pkg::ST_POWER_UP_STEP_ONE;
      pss_pkg::ST_ASLEEP: if (wake_hit) state_next = pss_pkg::ST_POWER_UP_STEP_ONE;
      pss_pkg::ST_POWER_UP_STEP_ONE: if (step_end) state_next = pss_pkg::ST_POWER_UP_STEP_TWO;
      pss_pkg::ST_POWER_UP_STEP_TWO: if (step_end) state_next = pss_pkg::ST_AWAKE_WAIT;
      pss_pkg::ST_AWAKE_WAIT: if (rails_good) state_next = pss_pkg::ST_AWAKE;
      pss_pkg::ST_AWAKE: if (sleep_req_reg) state_next = pss_pkg::ST_POWER_DOWN_STEP_ONE;
      pss_pkg::ST_POWER_DOWN_STEP_ONE:
        if (step_end) state_next = pss_pkg::ST_POWER_DOWN_STEP_TWO;
      pss_pkg::ST_POWER_DOWN_STEP_TWO: if (step_end) state_next = pss_pkg::ST_ASLEEP;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= pss_pkg::ST_RESET;
      step_cnt_reg <= 16'h0000;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      if (state_next != state_reg)
        step_cnt_reg <= 16'h0000;
      else
        step_cnt_reg <= step_cnt_reg + 16'h0001;
    end
  end

  // Settings applied on entry; awake edits need the reapply strobe
  logic [31:0] applied_reg;
  logic [3:0] prev_reg;
  logic [3:0] applied_en;

  assign applied_en = {applied_reg[pss_pkg::B_IO_EN], applied_reg[pss_pkg::B_PLL_EN],
                       applied_reg[pss_pkg::B_ANA_EN], applied_reg[pss_pkg::B_CORE_EN]};

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      applied_reg <= 32'h0000_0000;
      prev_reg <= pss_pkg::PREV_RST;
    end
    else if (ce)
    begin
      if (state_next != state_reg)
      begin
        applied_reg <= cfg_for(state_next, awake_cfg_reg, slp1_cfg_reg);
        prev_reg <= applied_en;
      end
      else if (reapply_reg)
        applied_reg <= awake_cfg_reg & pss_pkg::CFG_MASK;
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_ev;
  logic [2:0] irq_clr;
  logic irq_reg;

  assign irq_ev[pss_pkg::IRQ_AWAKE] = state_next == pss_pkg::ST_AWAKE
                                      && state_reg != pss_pkg::ST_AWAKE;
  assign irq_ev[pss_pkg::IRQ_ASLEEP] = state_next == pss_pkg::ST_ASLEEP
                                       && state_reg != pss_pkg::ST_ASLEEP;
  assign irq_ev[pss_pkg::IRQ_WAKE] = wake_hit;
  assign irq_clr = (wr_acc && avs_address == pss_pkg::OFS_IRQ_STAT && avs_byteenable[0])
                   ? wdata[2:0] : 3'h0;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_stat_reg <= 3'h0;
      irq_reg <= 1'b0;
    end
    else if (ce)
    begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================
  // Read data
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      pss_pkg::OFS_GEN_CTRL:
      begin
        rd_mux = gen_reg;
        rd_mux[pss_pkg::B_G_SLEEP] = sleep_req_reg;
      end
      pss_pkg::OFS_WAKE_LO: rd_mux = wake_lo_reg;
      pss_pkg::OFS_WAKE_HI: rd_mux = wake_hi_reg;
      pss_pkg::OFS_AWAKE_CFG: rd_mux = awake_cfg_reg;
      pss_pkg::OFS_SLP1_CFG: rd_mux = slp1_cfg_reg;
      pss_pkg::OFS_SEQ_STAT:
      begin
        rd_mux = applied_reg;
        rd_mux[pss_pkg::B_PREV_PLL +: 2] = prev_reg[3:2];
        rd_mux[pss_pkg::B_PREV_CORE +: 2] = prev_reg[1:0];
        rd_mux[pss_pkg::B_STATE_LSB +: 3] = state_reg;
      end
      pss_pkg::OFS_CONV_CTRL: rd_mux = conv_reg;
      pss_pkg::OFS_SUP_STAT:
      begin
        rd_mux[pss_pkg::B_OSC_OK] = sup_sync[6];
        rd_mux[pss_pkg::B_PLL_GOOD] = sup_sync[5];
        rd_mux[pss_pkg::B_CORE_GOOD] = sup_sync[4];
        rd_mux[pss_pkg::B_LIMIT_LSB +: 2] = sup_sync[3:2];
        rd_mux[pss_pkg::B_SOFT_LSB +: 2] = sup_sync[1:0];
      end
      pss_pkg::OFS_CORE_LVL: rd_mux[6:0] = core_lvl_reg;
      pss_pkg::OFS_PLL_LVL: rd_mux = pll_lvl_reg;
      pss_pkg::OFS_IRQ_STAT: rd_mux[2:0] = irq_stat_reg;
      pss_pkg::OFS_IRQ_MASK: rd_mux[2:0] = irq_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (ce && rd_start)
      avs_readdata <= rd_mux;
  end

  // ==========================================================
  // Outputs
  assign avs_waitrequest = wait_reg;
  assign io_supply_output_en = applied_reg[pss_pkg::B_IO_EN];
  assign pll_linear_regulator_en = applied_reg[pss_pkg::B_PLL_EN];
  assign analogue_buck_converter_en = applied_reg[pss_pkg::B_ANA_EN];
  assign core_buck_converter_en = applied_reg[pss_pkg::B_CORE_EN];
  assign analogue_buck_pfm = applied_reg[pss_pkg::B_ANA_PFM];
  assign core_buck_pfm = applied_reg[pss_pkg::B_CORE_PFM];
  assign tile_clock_stop = applied_reg[pss_pkg::B_TILE_STOP];
  assign core_rail_level = core_lvl_reg;
  assign pll_regulator_level = pll_lvl_reg;
  assign converter_control = conv_reg;
  assign irq = irq_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence enter_awake_s;
    ce && state_reg == pss_pkg::ST_AWAKE_WAIT && rails_good && !reapply_reg;
  endsequence

  sequence sleep_cmd_s;
    ce && state_reg == pss_pkg::ST_AWAKE && sleep_req_reg;
  endsequence

  sleep_entry_a: assert property (sleep_cmd_s |=>
    state_reg == pss_pkg::ST_POWER_DOWN_STEP_ONE ##0 applied_reg == $past(slp1_cfg_reg))
    else $error("sleep command did not enter power down step one");
  step_hold_a: assert property ($rose(state_reg == pss_pkg::ST_POWER_UP_STEP_ONE) |->
    (state_reg == pss_pkg::ST_POWER_UP_STEP_ONE)[*4])
    else $error("power up step one left too early");
  wake_lower_a: assert property (ce && state_reg == pss_pkg::ST_ASLEEP && timer_en && !use64
    && rtc_time[31:0] >= wake_lo_reg |=> state_reg == pss_pkg::ST_POWER_UP_STEP_ONE)
    else $error("lower word match did not wake");
  upper_ignored_a: assert property (ce && state_reg == pss_pkg::ST_ASLEEP
    && (!timer_en || (!use64 && rtc_time[31:0] < wake_lo_reg))
    |=> state_reg == pss_pkg::ST_ASLEEP)
    else $error("woke without a valid timer match");
  tile_stop_a: assert property (enter_awake_s |=>
    tile_clock_stop == $past(awake_cfg_reg[pss_pkg::B_TILE_STOP])
    && core_buck_pfm == $past(awake_cfg_reg[pss_pkg::B_CORE_PFM]))
    else $error("awake tile clock or modulation not applied");
  awake_en_a: assert property (enter_awake_s |=> analogue_buck_converter_en
    && core_buck_converter_en == $past(awake_cfg_reg[pss_pkg::B_CORE_EN]))
    else $error("awake supply enables not applied");
  prev_snap_a: assert property (ce && state_next != state_reg |=>
    prev_reg == $past(applied_en))
    else $error("previous state snapshot wrong");
  core_level_a: assert property (ce && boot_cap |=>
    core_rail_level == 7'(pss_pkg::CORE_LVL_BASE + {3'h0, $past(mode_sync)}))
    else $error("core level not loaded from straps");
  level_max_a: assert property (core_rail_level <= pss_pkg::CORE_LVL_MAX)
    else $error("core level above top code");
  irq_level_a: assert property (ce |=> irq == $past(|(irq_stat_reg & irq_mask_reg)))
    else $error("interrupt output disagrees with status and mask");

endmodule // pss_power_ctrl

/* pss_supply_model.sv */
// Behavioural regulators and sleep oscillator behind the power controller
`timescale 1ns/1ps
module pss_supply_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic core_en,
  input wire logic pll_en,
  input wire logic ana_en,
  input wire logic [1:0] lim_cmd,
  output logic osc_ok,
  output logic pll_good,
  output logic core_good,
  output logic ana_lim,
  output logic core_lim,
  output logic ana_soft,
  output logic core_soft
);
  // ==========================================
  // Ramp counters, cleared when a supply drops
  logic [3:0] core_reg, pll_reg, ana_reg, osc_reg;

  function automatic logic [3:0] ramp(input logic en, input logic [3:0] c);
    return !en ? 4'h0 : (c == 4'hF ? c : c + 4'h1);
  endfunction

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      core_reg <= 4'h0;
      pll_reg <= 4'h0;
      ana_reg <= 4'h0;
      osc_reg <= 4'h0;
    end
    else
    begin
      core_reg <= ramp(core_en, core_reg);
      pll_reg <= ramp(pll_en, pll_reg);
      ana_reg <= ramp(ana_en, ana_reg);
      osc_reg <= ramp(1'b1, osc_reg);
    end
  end

  // ==========================================
  // Status levels
  assign osc_ok = osc_reg >= 4'h6;
  assign core_good = core_reg >= 4'h5;
  assign pll_good = pll_reg >= 4'h5;
  assign core_soft = core_en && core_reg < 4'h4;
  assign ana_soft = ana_en && ana_reg < 4'h4;
  // Limiting only on command, and only from a running converter
  assign core_lim = core_en & lim_cmd[0];
  assign ana_lim = ana_en & lim_cmd[1];
endmodule // pss_supply_model

/* power_state_supply_control_test.sv */
// Self-checking testbench of the power state and supply controller
`timescale 1ns/1ps
module power_state_supply_control_test;
  logic mclk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, pll_level, conv_ctrl, rd;
  logic [63:0] rtc_time;
  logic osc, pll_g, core_g, ana_l, core_l, ana_s, core_s;
  logic io_en, pll_en, ana_en, core_en, ana_pfm, core_pfm, tile_stop;
  logic [6:0] core_lvl;
  logic [1:0] lim_cmd;
  int err_total, checks;

  pss_power_ctrl #(.STEP_CYCLES(8)) dut (
    .mclk(mclk), .rst(rst), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rtc_time(rtc_time),
    .mode_pins(4'h3), .osc_stable_in(osc), .pll_rail_good_in(pll_g),
    .core_rail_good_in(core_g), .analogue_limit_in(ana_l), .core_limit_in(core_l),
    .analogue_softstart_in(ana_s), .core_softstart_in(core_s), .io_supply_output_en(io_en),
    .pll_linear_regulator_en(pll_en), .analogue_buck_converter_en(ana_en),
    .core_buck_converter_en(core_en), .analogue_buck_pfm(ana_pfm), .core_buck_pfm(core_pfm),
    .tile_clock_stop(tile_stop), .core_rail_level(core_lvl),
    .pll_regulator_level(pll_level), .converter_control(conv_ctrl), .irq(irq));

  pss_supply_model sup (
    .mclk(mclk), .rst(rst), .core_en(core_en), .pll_en(pll_en), .ana_en(ana_en),
    .lim_cmd(lim_cmd), .osc_ok(osc), .pll_good(pll_g), .core_good(core_g),
    .ana_lim(ana_l), .core_lim(core_l), .ana_soft(ana_s), .core_soft(core_s));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk or posedge rst)
    if (rst)
      rtc_time <= 64'h0;
    else
      rtc_time <= rtc_time + 64'h1;

  // ==========================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
      chk(32'h1, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, pss_pkg::OFS_SEQ_STAT, 32'h0);
      n++;
    end
    while (rd[18:16] !== s && n < 300);
    chk({29'h0, rd[18:16]}, {29'h0, s});
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset;
    rdc(pss_pkg::OFS_AWAKE_CFG, 32'h0000_0033);
    rdc(pss_pkg::OFS_CORE_LVL, 32'h0000_002B);
    chk({25'h0, core_lvl}, 32'h0000_002B);
    rdc(pss_pkg::OFS_CONV_CTRL, 32'h0000_0000);
    rdc(8'h60, 32'h0000_0000);
  endtask

  task automatic t_boot;
    wait_state(3'h5);
    chk({26'h0, rd[29:24]}, 32'h0000_0033);
    chk({28'h0, io_en, pll_en, ana_en, core_en}, 32'h0000_000F);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, pss_pkg::OFS_IRQ_MASK, 32'h0000_0007);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    rdc(pss_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    bus(1'b1, pss_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_cfg;
    bus(1'b1, pss_pkg::OFS_AWAKE_CFG, 32'h0000_4300);
    rdc(pss_pkg::OFS_AWAKE_CFG, 32'h0000_4302);
    bus(1'b1, pss_pkg::OFS_AWAKE_CFG, 32'h0000_4331);
    bus(1'b1, pss_pkg::OFS_GEN_CTRL, 32'h0000_0040);
    repeat (3) @(posedge mclk);
    chk({25'h0, tile_stop, ana_pfm, core_pfm, io_en, pll_en, ana_en, core_en}, 32'h7F);
  endtask

  task automatic t_status;
    rdc(pss_pkg::OFS_SUP_STAT, 32'h0109_0000);
    lim_cmd <= 2'h3;
    repeat (4) @(posedge mclk);
    rdc(pss_pkg::OFS_SUP_STAT, 32'h0109_0300);
    lim_cmd <= 2'h0;
  endtask

  task automatic t_level;
    // One code up, then a 1 us wait before the level output is checked
    bus(1'b1, pss_pkg::OFS_CORE_LVL, 32'h0000_002C);
    repeat (100) @(posedge mclk);
    chk({25'h0, core_lvl}, 32'h0000_002C);
    bus(1'b1, pss_pkg::OFS_CORE_LVL, 32'h0000_007F);
    rdc(pss_pkg::OFS_CORE_LVL, 32'h0000_0046);
    bus(1'b1, pss_pkg::OFS_PLL_LVL, 32'h0000_0001);
    // The write lands on the edge the task returns at; look one edge later
    @(posedge mclk);
    chk(pll_level, 32'h0000_0001);
    bus(1'b1, pss_pkg::OFS_CONV_CTRL, 32'hA5A5_5A5A);
    @(posedge mclk);
    chk(conv_ctrl, 32'hA5A5_5A5A);
  endtask

  task automatic t_sleep;
    bus(1'b1, pss_pkg::OFS_WAKE_LO, 32'h0000_0000);
    bus(1'b1, pss_pkg::OFS_WAKE_HI, 32'hFFFF_FFFF);
    bus(1'b1, pss_pkg::OFS_GEN_CTRL, 32'h0000_0032);
    wait_state(3'h1);
    chk({26'h0, rd[29:24]}, 32'h0000_0002);
    chk({30'h0, tile_stop, core_en}, 32'h0000_0002);
    repeat (20) @(posedge mclk);
    wait_state(3'h1);
    bus(1'b1, pss_pkg::OFS_GEN_CTRL, 32'h0000_0010);
    wait_state(3'h5);
    rdc(pss_pkg::OFS_IRQ_STAT, 32'h0000_0007);
  endtask

  task automatic give_verdict;
    $display("errors=%0d checks=%0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    lim_cmd = 2'h0;
    err_total = 0;
    checks = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_boot();
    t_cfg();
    t_status();
    t_level();
    t_sleep();
    give_verdict();
  end

  initial
  begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule // power_state_supply_control_test
